// ### hdl/gpb_pin_bank.sv
// register bank and bus slave of the pin configuration bank
// Functional notes
// - bit 10 selects drive: zero push-pull, one open-drain.
// - bits 9:8: 00 input, 01 pull-up, 10 pull-down, 11 output.
// - analog-converter function makes bits 9:8 irrelevant to the pad.
// - port 1 pin 5 resets to pull-up, other fields zero.
// - port 1 pin 6 also resets to pull-up.
// - port 1 pin 7, port 2 pins 0-3 reset to pull-down, rest zero.
// - seven registers, indices two apart, port 1 pin 5 first.
`timescale 1ns/1ps
module gpb_pin_bank
#(
	parameter int         NUM_PINS = gpb_pkg::NUM_PINS,
	parameter logic [5:0] ADC_FUNC = gpb_pkg::DEF_ADC_FUNC
)
(
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	output gpb_pkg::gpb_pad_s      padCtrl [NUM_PINS]
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (NUM_PINS != gpb_pkg::NUM_PINS)
	begin : g_bad_count
		$error("pin count must match the register index table");
	end

	// neighbouring registers sit two index steps apart
	for (genvar k = 1; k < gpb_pkg::NUM_PINS; k++)
	begin : g_idx_step
		if (gpb_pkg::REG_IDX[k] - gpb_pkg::REG_IDX[k - 1] != 32'h00000002)
		begin : g_bad_step
			$error("register indices must be two apart");
		end
	end

	// last slot must still fit the decoded bits 7:2
	if (gpb_pkg::REG_IDX[gpb_pkg::NUM_PINS - 1] - gpb_pkg::IDX_BASE >
		32'h0000003f)
	begin : g_bad_span
		$error("register window wider than the decoded address");
	end

	// ************************************************************
	// helpers
	// ************************************************************
	localparam int SW = $clog2(gpb_pkg::NUM_PINS + 1);

	// word slot of register k inside the block window
	function automatic logic [5:0] slotOf(input int k);
		logic [31:0] d;
		d = gpb_pkg::REG_IDX[k] - gpb_pkg::IDX_BASE;
		return d[5:0];
	endfunction

	// address to pin number, NUM_PINS when unmapped
	function automatic logic [SW-1:0] decodeSlot(input logic [31:0] a);
		logic [SW-1:0] s;
		s = SW'(gpb_pkg::NUM_PINS);
		for (int k = 0; k < gpb_pkg::NUM_PINS; k++)
			if (a[7:2] == slotOf(k))
				s = SW'(k);
		return s;
	endfunction

	// ************************************************************
	// address phase capture
	// ************************************************************
	logic                addrTaken;
	logic [SW-1:0]       addrSlot;
	logic                wrPend_q;
	logic [SW-1:0]       wrSlot_q;
	gpb_pkg::gpb_cfg_s   cfgAll [NUM_PINS];

	assign addrTaken = hsel && hready && htrans[1];
	assign addrSlot  = decodeSlot(haddr);

	// remember a write until its data phase
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wrPend_q <= 1'b0;
			wrSlot_q <= '0;
		end
		else
		begin
			wrPend_q <= addrTaken && hwrite;
			if (addrTaken && hwrite)
				wrSlot_q <= addrSlot;
		end
	end

	// ************************************************************
	// configuration registers
	// ************************************************************
	for (genvar k = 0; k < NUM_PINS; k++)
	begin : g_pin
		gpb_pin_cell
		#(
			.RST_PULL (gpb_pkg::resetPull(k)),
			.ADC_FUNC (ADC_FUNC)
		)
		u_cell
		(
			.core_clk (core_clk),
			.rst      (rst),
			.wrEn     (wrPend_q && wrSlot_q == SW'(k)),
			.wrData   (gpb_pkg::halfToCfg(hwdata[15:0])),
			.cfg_q    (cfgAll[k]),
			.pad_q    (padCtrl[k])
		);
	end

	// ************************************************************
	// read data and response
	// ************************************************************
	// read image taken in address phase, shown in data phase
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			hrdata <= 32'h00000000;
		else if (addrTaken && !hwrite)
		begin
			hrdata <= 32'h00000000;
			for (int k = 0; k < NUM_PINS; k++)
				if (addrSlot == SW'(k))
					hrdata <= {16'h0000,
						gpb_pkg::cfgToHalf(cfgAll[k])};
		end
	end

	// zero-wait slave, always okay
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			hreadyout <= 1'b1;
			hresp     <= gpb_pkg::HRESP_OKAY;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= gpb_pkg::HRESP_OKAY;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence sReadMapped;
		addrTaken && !hwrite && addrSlot < SW'(NUM_PINS);
	endsequence

	sequence sReadUnmapped;
		addrTaken && !hwrite && addrSlot == SW'(NUM_PINS);
	endsequence

	sequence sWriteP1Pin5;
		addrTaken && hwrite && haddr[7:2] == 6'h00;
	endsequence

	sequence sWriteTaken;
		addrTaken && hwrite;
	endsequence

	sequence sWriteApplied;
		wrPend_q && wrSlot_q < SW'(NUM_PINS);
	endsequence

	a_reserved_zero: assert property (@(posedge core_clk)
		disable iff (rst)
		hrdata[31:11] == 21'h000000 && hrdata[7:6] == 2'h0)
		else $error("reserved read bits not zero");

	a_unmapped_zero: assert property (@(posedge core_clk)
		disable iff (rst)
		sReadUnmapped |=> hrdata == 32'h00000000)
		else $error("unmapped read not zero");

	a_read_image: assert property (@(posedge core_clk)
		disable iff (rst)
		sReadMapped |=> hrdata[15:0] ==
		gpb_pkg::cfgToHalf($past(cfgAll[addrSlot])))
		else $error("read data does not match register");

	a_first_slot: assert property (@(posedge core_clk)
		disable iff (rst)
		sWriteP1Pin5 ##1 1'b1 |=> cfgAll[0] ==
		gpb_pkg::halfToCfg($past(hwdata[15:0])))
		else $error("slot zero write missed first pin");

	a_pad_open_drain: assert property (@(posedge core_clk)
		disable iff (rst)
		cfgAll[1].driveTypeSelect ##1 cfgAll[1].driveTypeSelect |->
		padCtrl[1].openDrain)
		else $error("open drain not reaching pad");

	a_reset_pull_up: assert property (@(posedge core_clk)
		$fell(rst) |-> cfgAll[1].directionPullSelect == 2'h1 &&
		cfgAll[0].directionPullSelect == 2'h1)
		else $error("pull-up pins wrong after reset");

	a_reset_pull_dn: assert property (@(posedge core_clk)
		$fell(rst) |-> cfgAll[2].directionPullSelect == 2'h2 &&
		cfgAll[6].directionPullSelect == 2'h2)
		else $error("pull-down pins wrong after reset");

	a_bus_ready: assert property (@(posedge core_clk) disable iff (rst)
		hreadyout && hresp == 1'b0)
		else $error("slave stalled or errored");

	a_write_pending: assert property (@(posedge core_clk)
		disable iff (rst)
		sWriteTaken |=> wrPend_q && wrSlot_q == $past(addrSlot))
		else $error("write address not carried to its data phase");

	a_no_stray_write: assert property (@(posedge core_clk)
		disable iff (rst)
		!(addrTaken && hwrite) |=> !wrPend_q)
		else $error("write pending without a write address phase");

	a_read_holds: assert property (@(posedge core_clk)
		disable iff (rst)
		!(addrTaken && !hwrite) |=> $stable(hrdata))
		else $error("read data changed without a read");

	a_write_image: assert property (@(posedge core_clk)
		disable iff (rst)
		sWriteApplied |=> gpb_pkg::cfgToHalf(cfgAll[$past(wrSlot_q)]) ==
		($past(hwdata[15:0]) & 16'h073f))
		else $error("written halfword not stored with reserved bits clear");

	// properties repeated for every pin register
	for (genvar k = 0; k < NUM_PINS; k++)
	begin : g_chk
		a_other_kept: assert property (@(posedge core_clk)
			disable iff (rst)
			wrPend_q && wrSlot_q != SW'(k) |=> $stable(cfgAll[k]))
			else $error("write disturbed another pin register");

		a_reset_image: assert property
			(@(posedge core_clk) $fell(rst) |->
			gpb_pkg::cfgToHalf(cfgAll[k]) == {6'h00,
			(k < gpb_pkg::PULL_UP_PINS) ? gpb_pkg::RST_PULL_HI :
			gpb_pkg::RST_PULL_LO, 8'h00})
			else $error("pin register not at its reset image");

		a_reset_pads: assert property
			(@(posedge core_clk) disable iff (rst)
			$fell(rst) && gpb_pkg::RST_FUNC != ADC_FUNC |=>
			padCtrl[k].pullUpEn == (k < gpb_pkg::PULL_UP_PINS) &&
			padCtrl[k].pullDownEn == (k >= gpb_pkg::PULL_UP_PINS) &&
			!padCtrl[k].outputEn && !padCtrl[k].openDrain)
			else $error("pad controls wrong after reset");

		a_pad_zero: assert property (@(posedge core_clk)
			rst |-> padCtrl[k] == '0)
			else $error("pad controls not cleared in reset");

		a_pad_func: assert property (@(posedge core_clk)
			disable iff (rst)
			!rst |=> padCtrl[k].functionSelect ==
			$past(cfgAll[k].functionSelect))
			else $error("function select not routed to the pad");

		a_pad_drive: assert property (@(posedge core_clk)
			disable iff (rst)
			!rst |=> padCtrl[k].openDrain ==
			$past(cfgAll[k].driveTypeSelect))
			else $error("drive type not routed to the pad");

		a_pad_pulls: assert property (@(posedge core_clk)
			disable iff (rst)
			!rst && cfgAll[k].functionSelect != ADC_FUNC |=>
			padCtrl[k].pullUpEn ==
			($past(cfgAll[k].directionPullSelect) == gpb_pkg::PULL_UP) &&
			padCtrl[k].pullDownEn ==
			($past(cfgAll[k].directionPullSelect) == gpb_pkg::PULL_DOWN))
			else $error("pull request not reaching the pad");

		a_pad_output: assert property (@(posedge core_clk)
			disable iff (rst)
			!rst && cfgAll[k].functionSelect != ADC_FUNC |=>
			padCtrl[k].outputEn ==
			($past(cfgAll[k].directionPullSelect) == gpb_pkg::PULL_OUT))
			else $error("output request not reaching the pad");

		a_pad_analog: assert property (@(posedge core_clk)
			disable iff (rst)
			!rst |=> padCtrl[k].analogSel ==
			($past(cfgAll[k].functionSelect) == ADC_FUNC))
			else $error("analog selection not reaching the pad");
	end

endmodule

// ### hdl/gpb_pin_cell.sv
// one pin configuration register with its registered pad decode
`timescale 1ns/1ps
module gpb_pin_cell
#(
	parameter logic [1:0] RST_PULL = gpb_pkg::RST_PULL_LO,
	parameter logic [5:0] ADC_FUNC = gpb_pkg::DEF_ADC_FUNC
)
(
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             wrEn,
	input  wire gpb_pkg::gpb_cfg_s wrData,
	output gpb_pkg::gpb_cfg_s     cfg_q,
	output gpb_pkg::gpb_pad_s     pad_q
);

	// ************************************************************
	// configuration storage
	// ************************************************************
	// software write, reset picks per-pin pull code
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_q.driveTypeSelect     <= gpb_pkg::RST_DRIVE;
			cfg_q.directionPullSelect <= RST_PULL;
			cfg_q.functionSelect      <= gpb_pkg::RST_FUNC;
		end
		else if (wrEn)
			cfg_q <= wrData;
	end

	// ************************************************************
	// pad control decode
	// ************************************************************
	// analog function forces pulls and driver off
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			pad_q <= '0;
		else
		begin
			pad_q.openDrain      <= cfg_q.driveTypeSelect;
			pad_q.functionSelect <= cfg_q.functionSelect;
			pad_q.analogSel      <= (cfg_q.functionSelect == ADC_FUNC);
			if (cfg_q.functionSelect == ADC_FUNC)
			begin
				pad_q.pullUpEn   <= 1'b0;
				pad_q.pullDownEn <= 1'b0;
				pad_q.outputEn   <= 1'b0;
			end
			else
			begin
				pad_q.pullUpEn   <= (cfg_q.directionPullSelect ==
					gpb_pkg::PULL_UP);
				pad_q.pullDownEn <= (cfg_q.directionPullSelect ==
					gpb_pkg::PULL_DOWN);
				pad_q.outputEn   <= (cfg_q.directionPullSelect ==
					gpb_pkg::PULL_OUT);
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_reset_value: assert property (@(posedge core_clk)
		$fell(rst) |-> cfg_q.directionPullSelect == RST_PULL &&
		cfg_q.functionSelect == 6'h00 && !cfg_q.driveTypeSelect)
		else $error("config not at reset value after reset");

	a_write_lands: assert property (@(posedge core_clk)
		disable iff (rst)
		wrEn |=> cfg_q == $past(wrData))
		else $error("written config not stored");

	a_adc_ignores_pull: assert property (@(posedge core_clk)
		disable iff (rst)
		cfg_q.functionSelect == ADC_FUNC ##1 !$past(wrEn) |->
		!pad_q.pullUpEn && !pad_q.pullDownEn && !pad_q.outputEn)
		else $error("analog pin still has pull or driver");

	a_pull_decode: assert property (@(posedge core_clk)
		disable iff (rst)
		cfg_q.functionSelect != ADC_FUNC &&
		cfg_q.directionPullSelect == 2'h3 |=> pad_q.outputEn &&
		!pad_q.pullUpEn && !pad_q.pullDownEn)
		else $error("output code not decoded");

endmodule

// ### hdl/gpb_pkg.sv
// constants, field layout and carrier types for the pin configuration bank
package gpb_pkg;

	// ************************************************************
	// bank size and register indices
	// ************************************************************
	localparam int          NUM_PINS     = 7;
	localparam logic [31:0] IDX_P1_PIN5  = 32'h50003038;
	localparam logic [31:0] IDX_P1_PIN6  = 32'h5000303a;
	localparam logic [31:0] IDX_P1_PIN7  = 32'h5000303c;
	localparam logic [31:0] IDX_P2_PIN0  = 32'h5000303e;
	localparam logic [31:0] IDX_P2_PIN1  = 32'h50003040;
	localparam logic [31:0] IDX_P2_PIN2  = 32'h50003042;
	localparam logic [31:0] IDX_P2_PIN3  = 32'h50003044;
	localparam logic [31:0] IDX_BASE     = IDX_P1_PIN5;
	localparam logic [31:0] REG_IDX [NUM_PINS] = '{IDX_P1_PIN5, IDX_P1_PIN6,
		IDX_P1_PIN7, IDX_P2_PIN0, IDX_P2_PIN1, IDX_P2_PIN2, IDX_P2_PIN3};

	// ************************************************************
	// field positions and encodings
	// ************************************************************
	localparam int          DRIVE_POS    = 10;
	localparam int          PULL_MSB     = 9;
	localparam int          PULL_LSB     = 8;
	localparam int          FUNC_MSB     = 5;
	localparam int          FUNC_LSB     = 0;
	localparam logic [1:0]  PULL_NONE    = 2'h0;
	localparam logic [1:0]  PULL_UP      = 2'h1;
	localparam logic [1:0]  PULL_DOWN    = 2'h2;
	localparam logic [1:0]  PULL_OUT     = 2'h3;
	localparam logic [5:0]  DEF_ADC_FUNC = 6'h0f; // arbitrary value

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic        RST_DRIVE    = 1'b0;
	localparam logic [5:0]  RST_FUNC     = 6'h00;
	localparam int          PULL_UP_PINS = 2;
	localparam logic [1:0]  RST_PULL_HI  = 2'h1;
	localparam logic [1:0]  RST_PULL_LO  = 2'h2;

	// ************************************************************
	// bus encodings
	// ************************************************************
	localparam logic [1:0]  HTRANS_IDLE  = 2'h0;
	localparam logic        HRESP_OKAY   = 1'b0;

	// ************************************************************
	// carrier types
	// ************************************************************
	typedef struct packed {
		logic       driveTypeSelect;
		logic [1:0] directionPullSelect;
		logic [5:0] functionSelect;
	} gpb_cfg_s;

	typedef struct packed {
		logic       openDrain;
		logic       pullUpEn;
		logic       pullDownEn;
		logic       outputEn;
		logic       analogSel;
		logic [5:0] functionSelect;
	} gpb_pad_s;

	// reset pull code of one pin
	function automatic logic [1:0] resetPull(input int pin);
		return (pin < PULL_UP_PINS) ? RST_PULL_HI : RST_PULL_LO;
	endfunction

	// config to halfword image, reserved bits zero
	function automatic logic [15:0] cfgToHalf(input gpb_cfg_s c);
		logic [15:0] h;
		h = 16'h0000;
		h[DRIVE_POS] = c.driveTypeSelect;
		h[PULL_MSB:PULL_LSB] = c.directionPullSelect;
		h[FUNC_MSB:FUNC_LSB] = c.functionSelect;
		return h;
	endfunction

	// halfword image to config, reserved bits dropped
	function automatic gpb_cfg_s halfToCfg(input logic [15:0] h);
		gpb_cfg_s c;
		c.driveTypeSelect = h[DRIVE_POS];
		c.directionPullSelect = h[PULL_MSB:PULL_LSB];
		c.functionSelect = h[FUNC_MSB:FUNC_LSB];
		return c;
	endfunction

endpackage

// ### tb/tb_gpb_pin_bank.sv
// self-checking bench for the pin configuration bank
`timescale 1ns/1ps
module tb_gpb_pin_bank;

	// ************************************************************
	// signals and design instance
	// ************************************************************
	localparam logic [5:0] ADC_CODE = 6'h0f; // arbitrary analog code
	logic              core_clk = 1'b0;
	logic              rst = 1'b1;
	logic              hsel = 1'b0;
	logic [31:0]       haddr = 32'h0;
	logic [1:0]        htrans = 2'h0;
	logic              hwrite = 1'b0;
	logic [2:0]        hsize = 3'h2;
	logic [31:0]       hwdata = 32'h0;
	logic [31:0]       hrdata;
	logic              hreadyout;
	logic              hresp;
	gpb_pkg::gpb_pad_s padCtrl [gpb_pkg::NUM_PINS];
	int                failures = 0;
	int                cmp_count = 0;

	// single slave, so its ready is the bus ready
	gpb_pin_bank #(
		.NUM_PINS (gpb_pkg::NUM_PINS),
		.ADC_FUNC (ADC_CODE)
	) i_dut (
		.core_clk  (core_clk),
		.rst       (rst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.padCtrl   (padCtrl)
	);

	// 200 MHz clock
	always #2.5 core_clk = ~core_clk;

	// ************************************************************
	// helpers and bus cycles
	// ************************************************************
	// verdict and end of run
	task automatic complete_run;
		if (failures == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// byte address of one pin register in the block window
	function automatic logic [31:0] regAddr(input int p);
		return (gpb_pkg::REG_IDX[p] - gpb_pkg::IDX_BASE) << 2;
	endfunction

	// expected pad image from drive, pull code and function
	function automatic logic [31:0] padExp(input logic [15:0] r);
		logic an;
		an = (r[5:0] == ADC_CODE);
		return {21'h0, r[10], !an && r[9:8] == 2'h1, !an && r[9:8] == 2'h2,
			!an && r[9:8] == 2'h3, an, r[5:0]};
	endfunction

	// wait for the ready edge
	task automatic waitReady;
		@(posedge core_clk);
		while (hreadyout !== 1'b1)
			@(posedge core_clk);
	endtask

	// address phase then data phase
	task automatic busCycle(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		waitReady();
		hsel <= 1'b0;
		htrans <= gpb_pkg::HTRANS_IDLE;
		hwdata <= d;
		waitReady();
	endtask

	// read one word and check the response code
	task automatic busRead(input logic [31:0] a, output logic [31:0] d);
		busCycle(1'b0, a, 32'h0);
		d = hrdata;
		check({31'h0, hresp}, {31'h0, gpb_pkg::HRESP_OKAY});
		check({31'h0, hreadyout}, 32'h00000001);
	endtask

	// read back one pin register and check its pad decode
	task automatic checkPin(input int p, input logic [15:0] r);
		logic [31:0] d;
		busRead(regAddr(p), d);
		check(d, {16'h0, r});
		check(32'(padCtrl[p]), padExp(r));
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	// reset images of all pins
	task automatic testReset;
		for (int p = 0; p < gpb_pkg::NUM_PINS; p++)
			checkPin(p, (p < 2) ? 16'h0100 : 16'h0200);
	endtask

	// unmapped word reads zero, write lands nowhere
	task automatic testUnmapped;
		logic [31:0] d;
		busCycle(1'b1, 32'h4, 32'hffff_ffff);
		busRead(32'h4, d);
		check(d, 32'h0);
	endtask

	// distinct values per pin, reserved bits set in the write
	task automatic testFields;
		logic [15:0] v;
		for (int p = 0; p < gpb_pkg::NUM_PINS; p++)
		begin
			v = {5'h1f, p[0], p[1:0], 2'h3, 6'(p) + 6'h10};
			busCycle(1'b1, regAddr(p), {16'hffff, v});
		end
		for (int p = 0; p < gpb_pkg::NUM_PINS; p++)
		begin
			v = {5'h0, p[0], p[1:0], 2'h0, 6'(p) + 6'h10};
			checkPin(p, v);
		end
	endtask

	// analog function masks every pull code
	task automatic testAdc;
		logic [15:0] v;
		for (int c = 0; c < 4; c++)
		begin
			v = {5'h0, 1'b1, 2'(c), 2'h0, ADC_CODE};
			busCycle(1'b1, regAddr(2), {16'h0, v});
			checkPin(2, v);
		end
	endtask

	// second reset in mid-run
	task automatic pulseReset;
		rst <= 1'b1;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
	endtask

	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial
	begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		testUnmapped();
		testReset();
		testFields();
		testAdc();
		pulseReset();
		testReset();
		complete_run();
	end

	// hang guard, far beyond the 84 or so cycles needed
	initial
	begin
		repeat (5000) @(posedge core_clk);
		failures++;
		complete_run();
	end

endmodule
